// >>> hdl/fec_pkg.sv
// Constants and types for the flash erase command controller
`default_nettype none
package fec_pkg;
	localparam int ADDR_W = 19;
	localparam int SECT_W = 3;
	localparam int CLK_MHZ = 40;
	// Unlock pairs: common defaults, adjust to the part in use
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002AA;
	localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam int SECT_LSB = 16;
	// Bus timing of one strobe phase
	localparam int PHASE_NS = 100;
	localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
	// Sector-load gap, a longest time: round down
	localparam int LOAD_GAP_US = 50;
	localparam int LOAD_GAP_CYC = LOAD_GAP_US * CLK_MHZ * 3 / 4;
	localparam int RESUME_GAP_MS = 10;
	localparam int RESUME_GAP_CYC = RESUME_GAP_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 20;
	// Status bit positions on the data bus
	localparam int POLL_BIT = 7;
	localparam int TOG1_BIT = 6;
	localparam int TMO_BIT = 5;
	localparam int ETMR_BIT = 3;
	localparam int STOG_BIT = 2;
	// AXI register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SECT = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_LAST = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Command codes in the control register
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_ERASE = 3'h1;
	localparam logic [2:0] OP_SUSPEND = 3'h2;
	localparam logic [2:0] OP_RESUME = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	typedef enum logic [3:0] {
		FS_IDLE = 4'h0,
		FS_WRITE = 4'h1,
		FS_LOADGAP = 4'h3,
		FS_POLL = 4'h2,
		FS_DONE = 4'h6,
		FS_FAIL = 4'h7
	} fec_state_t;
endpackage : fec_pkg
`default_nettype wire

// >>> hdl/fec_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, driven from the clock
`default_nettype none
module fec_bus_cycle
	import fec_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              start,
	input  wire logic              is_write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic [7:0]        dq_in,
	output logic                   busy,
	output logic                   done,
	output logic [7:0]             rdata_q,
	output logic [ADDR_W-1:0]      flash_addr_q,
	output logic [7:0]             dq_out_q,
	output logic                   dq_oe_q,
	output logic                   chip_select_n_q,
	output logic                   write_strobe_n_q,
	output logic                   output_gate_n_q
);
	logic [1:0] ph_q;
	logic [7:0] cnt_q;
	logic       wr_q;
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	logic [7:0] sync3_q;
	wire        cnt_end = cnt_q == 8'(PHASE_CYC - 1);
	assign busy = ph_q != 2'h0;
	assign done = ph_q == 2'h3 && cnt_end;
	always_ff @(posedge clock)
	begin
		sync1_q <= dq_in;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
	end
	// Address setup, strobe low, strobe high recovery; chip select held low
	// across the strobe so address latches on it and data on its rise
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			ph_q <= 2'h0;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			rdata_q <= 8'h00;
			flash_addr_q <= '0;
			dq_out_q <= 8'h00;
			dq_oe_q <= 1'b0;
			chip_select_n_q <= 1'b1;
			write_strobe_n_q <= 1'b1;
			output_gate_n_q <= 1'b1;
		end
		else if (ph_q == 2'h0)
		begin
			if (start)
			begin
				ph_q <= 2'h1;
				cnt_q <= 8'h00;
				wr_q <= is_write;
				flash_addr_q <= addr;
				dq_out_q <= wdata;
				dq_oe_q <= is_write;
				chip_select_n_q <= 1'b0;
			end
		end
		else if (!cnt_end)
			cnt_q <= cnt_q + 8'h01;
		else
		begin
			cnt_q <= 8'h00;
			ph_q <= ph_q + 2'h1;
			if (ph_q == 2'h1)
			begin
				write_strobe_n_q <= !wr_q;
				output_gate_n_q <= wr_q;
			end
			else if (ph_q == 2'h2)
			begin
				// Second and third stages agree at the clock edge that ends the strobe
				if (sync2_q == sync3_q)
					rdata_q <= sync3_q;
				write_strobe_n_q <= 1'b1;
				output_gate_n_q <= 1'b1;
			end
			else
			begin
				ph_q <= 2'h0;
				chip_select_n_q <= 1'b1;
				dq_oe_q <= 1'b0;
			end
		end
	end
endmodule : fec_bus_cycle
`default_nettype wire

// >>> hdl/fec_ctrl.sv
// Flash erase controller: AXI4-Lite registers and command sequencer
//
// The AXI4-Lite register port and the register offsets were decided locally.
`default_nettype none
module fec_ctrl
	import fec_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [ADDR_W-1:0]      flash_addr,
	input  wire logic [7:0]        flash_dq_in,
	output logic [7:0]             flash_dq_out,
	output logic                   flash_dq_oe,
	output logic                   chip_select_n,
	output logic                   write_strobe_n,
	output logic                   output_gate_n
);
	fec_state_t         state_q;
	logic [2:0]         op_q;
	logic [2:0]         step_q;
	logic [7:0]         sect_mask_q;
	logic [7:0]         pend_q;
	logic [SECT_W-1:0]  cur_sect_q;
	logic [CNT_W-1:0]   gap_q;
	logic [31:0]        resume_q;
	logic [7:0]         last_q;
	logic [7:0]         prev_q;
	logic               have_prev_q;
	logic               done_q;
	logic               fail_q;
	logic               susp_q;
	logic               req_q;
	logic [2:0]         req_op_q;
	logic               cyc_start;
	logic               cyc_write;
	logic [ADDR_W-1:0]  cyc_addr;
	logic [7:0]         cyc_data;
	logic               cyc_busy;
	logic               cyc_done;
	logic [7:0]         cyc_rdata;
	logic               aw_hold_q;
	logic               w_hold_q;
	logic [7:0]         aw_addr_q;
	logic [31:0]        w_data_q;
	logic [3:0]         w_strb_q;

	// AXI write path: address and data taken in either order
	wire aw_take = s_axi_awvalid && !aw_hold_q && !s_axi_bvalid;
	wire w_take = s_axi_wvalid && !w_hold_q && !s_axi_bvalid;
	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
	wire        wr_fire = aw_hold_q && w_hold_q;
	wire        wr_ctrl = aw_addr_q == REG_CTRL;
	wire        wr_sect = aw_addr_q == REG_SECT;
	wire        wr_ok = wr_ctrl || wr_sect;
	wire [2:0]  wr_op = w_data_q[2:0];
	wire        ctrl_new = wr_fire && wr_ctrl && w_strb_q[0] && wr_op != OP_NONE;
	wire [31:0] stat_word = {16'h0000, sect_mask_q, 1'b0, req_q, susp_q,
		fail_q, done_q, state_q == FS_POLL, state_q == FS_LOADGAP,
		state_q != FS_IDLE};

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			sect_mask_q <= 8'h00;
		end
		else
		begin
			if (aw_take)
			begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
				if (wr_sect && w_strb_q[0])
					sect_mask_q <= w_data_q[7:0];
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI read path
	assign s_axi_arready = !s_axi_rvalid;
	wire [31:0] rd_word = s_axi_araddr == REG_CTRL ? {29'h0, req_op_q} :
		s_axi_araddr == REG_SECT ? {24'h0, sect_mask_q} :
		s_axi_araddr == REG_STAT ? stat_word :
		s_axi_araddr == REG_LAST ? {24'h0, last_q} : 32'h0000_0000;
	wire rd_ok = s_axi_araddr <= REG_LAST && s_axi_araddr[1:0] == 2'h0;
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Sequence steps: address and data of each write cycle
	wire [ADDR_W-1:0] sect_addr = ADDR_W'({cur_sect_q, 16'h0000});
	wire [7:0] pend_low = pend_q & (~pend_q + 8'h01);
	wire       pend_more = (pend_q & ~pend_low) != 8'h00;
	// A fresh erase picks from the mask; pend_q is left empty by the last run
	wire [7:0] pick_src = state_q == FS_LOADGAP ? pend_q : sect_mask_q;
	logic [SECT_W-1:0] low_idx;
	always_comb
	begin
		low_idx = '0;
		for (int i = 7; i >= 0; i--)
			if (pick_src[i])
				low_idx = SECT_W'(i);
	end
	// Erase: unlock, unlock, setup, unlock, unlock, sector 30H
	always_comb
	begin
		cyc_addr = UNLOCK1_ADDR;
		cyc_data = UNLOCK1_DATA;
		case (op_q)
			OP_ERASE:
			case (step_q)
				3'h0, 3'h3: cyc_data = UNLOCK1_DATA;
				3'h1, 3'h4:
				begin
					cyc_addr = UNLOCK2_ADDR;
					cyc_data = UNLOCK2_DATA;
				end
				3'h2: cyc_data = CMD_SETUP;
				default:
				begin
					cyc_addr = sect_addr;
					cyc_data = CMD_SECTOR;
				end
			endcase
			OP_SUSPEND:
			begin
				cyc_addr = sect_addr;
				cyc_data = CMD_SUSPEND;
			end
			OP_RESUME:
			begin
				cyc_addr = sect_addr;
				cyc_data = CMD_RESUME;
			end
			default: cyc_data = CMD_RESET;
		endcase
	end

	wire gap_ok = resume_q == 32'h0;
	wire poll_done = have_prev_q && cyc_rdata[POLL_BIT] &&
		cyc_rdata[TOG1_BIT] == prev_q[TOG1_BIT];
	wire poll_fail = cyc_rdata[TMO_BIT] && !cyc_rdata[POLL_BIT];
	wire idle_now = state_q == FS_IDLE || state_q == FS_DONE ||
		state_q == FS_FAIL;
	// Suspend only has meaning while the erase runs, so it cuts in
	// between two status reads
	wire poll_susp = state_q == FS_POLL && op_q == OP_ERASE &&
		req_op_q == OP_SUSPEND;
	// Suspend waits out the resume spacing; other orders are not held by it
	wire req_go = req_q && (idle_now || poll_susp) && !cyc_busy &&
		(req_op_q != OP_SUSPEND || gap_ok);
	assign cyc_write = state_q != FS_POLL;
	// No read may start in the cycle that hands over to a write
	assign cyc_start = !cyc_busy && (state_q == FS_WRITE ||
		(state_q == FS_POLL && !req_go));

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			req_q <= 1'b0;
			req_op_q <= OP_NONE;
		end
		else if (ctrl_new)
		begin
			req_q <= 1'b1;
			req_op_q <= wr_op;
		end
		else if (req_go)
			req_q <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			resume_q <= 32'h0;
		else if (req_go && req_op_q == OP_RESUME)
			resume_q <= 32'(RESUME_GAP_CYC);
		else if (!gap_ok)
			resume_q <= resume_q - 32'h1;
	end

	// Power-up: device already reads array data, so no write is needed
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state_q <= FS_IDLE;
			op_q <= OP_NONE;
			step_q <= 3'h0;
			pend_q <= 8'h00;
			cur_sect_q <= '0;
			gap_q <= '0;
			last_q <= 8'h00;
			prev_q <= 8'h00;
			have_prev_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			susp_q <= 1'b0;
		end
		else
		case (state_q)
			FS_IDLE, FS_DONE, FS_FAIL:
			if (req_go)
			begin
				op_q <= req_op_q;
				step_q <= 3'h0;
				have_prev_q <= 1'b0;
				done_q <= 1'b0;
				state_q <= FS_WRITE;
				if (req_op_q == OP_ERASE)
				begin
					pend_q <= sect_mask_q;
					cur_sect_q <= low_idx;
					fail_q <= 1'b0;
				end
				else if (req_op_q == OP_RESET)
					fail_q <= 1'b0;
			end
			FS_WRITE:
			if (cyc_done)
			begin
				if (op_q == OP_ERASE && step_q != 3'h5)
					step_q <= step_q + 3'h1;
				else if (op_q == OP_ERASE)
				begin
					pend_q <= pend_q & ~pend_low;
					if (pend_more)
					begin
						// Next sector load must open within the timer window
						gap_q <= '0;
						state_q <= FS_LOADGAP;
					end
					else
						state_q <= FS_POLL;
				end
				else if (op_q == OP_SUSPEND)
				begin
					susp_q <= 1'b1;
					state_q <= FS_POLL;
				end
				else if (op_q == OP_RESUME)
				begin
					susp_q <= 1'b0;
					state_q <= FS_POLL;
				end
				else
				begin
					susp_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= FS_DONE;
				end
			end
			FS_LOADGAP:
			begin
				cur_sect_q <= low_idx;
				gap_q <= gap_q + CNT_W'(1);
				// Only another 30H may follow here, or the erase is cancelled
				if (gap_q == CNT_W'(LOAD_GAP_CYC / 8))
					state_q <= FS_WRITE;
			end
			FS_POLL:
			if (req_go)
			begin
				op_q <= req_op_q;
				step_q <= 3'h0;
				have_prev_q <= 1'b0;
				state_q <= FS_WRITE;
			end
			else if (cyc_done)
			begin
				last_q <= cyc_rdata;
				prev_q <= cyc_rdata;
				have_prev_q <= 1'b1;
				if (poll_fail)
				begin
					fail_q <= 1'b1;
					state_q <= FS_FAIL;
				end
				else if (op_q == OP_SUSPEND && have_prev_q &&
					cyc_rdata[POLL_BIT] &&
					cyc_rdata[TOG1_BIT] == prev_q[TOG1_BIT])
				begin
					state_q <= FS_DONE;
					done_q <= 1'b1;
				end
				else if (op_q != OP_SUSPEND && poll_done)
				begin
					done_q <= 1'b1;
					state_q <= FS_DONE;
				end
			end
			default: state_q <= FS_IDLE;
		endcase
	end

	fec_bus_cycle u_cycle (
		.clock           (clock),
		.resetn          (resetn),
		.start           (cyc_start),
		.is_write        (cyc_write),
		.addr            (state_q == FS_POLL ? sect_addr : cyc_addr),
		.wdata           (cyc_data),
		.dq_in           (flash_dq_in),
		.busy            (cyc_busy),
		.done            (cyc_done),
		.rdata_q         (cyc_rdata),
		.flash_addr_q    (flash_addr),
		.dq_out_q        (flash_dq_out),
		.dq_oe_q         (flash_dq_oe),
		.chip_select_n_q (chip_select_n),
		.write_strobe_n_q(write_strobe_n),
		.output_gate_n_q (output_gate_n)
	);

	a_poll_gives_done: assert property (
		@(posedge clock) disable iff (!resetn)
		state_q == FS_POLL && cyc_done && op_q == OP_ERASE && poll_done &&
		!poll_fail |=> state_q == FS_DONE && done_q)
		else $error("erase completion not recognised");
	a_fail_sets_flag: assert property (
		@(posedge clock) disable iff (!resetn)
		state_q == FS_POLL && cyc_done && poll_fail |=> fail_q)
		else $error("timeout status not latched");
	a_resume_spacing: assert property (
		@(posedge clock) disable iff (!resetn)
		req_go && req_op_q == OP_SUSPEND |-> resume_q == 32'h0)
		else $error("suspend issued inside resume spacing");
	a_sixth_is_sector: assert property (
		@(posedge clock) disable iff (!resetn)
		state_q == FS_WRITE && op_q == OP_ERASE && step_q == 3'h5 |->
		cyc_data == CMD_SECTOR && cyc_addr == sect_addr)
		else $error("sixth erase cycle not a sector load");
	a_setup_third: assert property (
		@(posedge clock) disable iff (!resetn)
		state_q == FS_WRITE && op_q == OP_ERASE && step_q == 3'h2 |->
		cyc_data == CMD_SETUP)
		else $error("setup byte missing");
	a_gap_bounded: assert property (
		@(posedge clock) disable iff (!resetn)
		state_q == FS_LOADGAP |-> gap_q <= CNT_W'(LOAD_GAP_CYC))
		else $error("sector load gap too long");
	a_reset_data: assert property (
		@(posedge clock) disable iff (!resetn)
		state_q == FS_WRITE && op_q == OP_RESET |-> cyc_data == CMD_RESET)
		else $error("reset command byte wrong");
	a_strobe_order: assert property (
		@(posedge clock) disable iff (!resetn)
		$fell(write_strobe_n) |-> !chip_select_n && $stable(flash_addr))
		else $error("write strobe without chip select");
	a_start_idle: assert property (
		@(posedge clock)
		!resetn |=> state_q == FS_IDLE && chip_select_n)
		else $error("not idle after reset");
endmodule : fec_ctrl
`default_nettype wire

// >>> tb/fec_flash_model.sv
// Behavioural flash device: command decoder, sector erase, status reads
`default_nettype none
module fec_flash_model
	import fec_pkg::*;
#(
	parameter int WINDOW_NS = 50000,
	parameter int ERASE_NS  = 20000
)
(
	input  wire logic [ADDR_W-1:0] flash_addr,
	input  wire logic [7:0]        flash_dq_out,
	input  wire logic              chip_select_n,
	input  wire logic              write_strobe_n,
	input  wire logic              output_gate_n,
	input  wire logic              overrun,
	output wire logic [7:0]        flash_dq_in,
	output logic [7:0]             erased_mask,
	output logic                   suspended,
	output logic                   erasing
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic         wr_n = chip_select_n | write_strobe_n;
	wire logic         rd_n = chip_select_n | output_gate_n;
	logic [ADDR_W-1:0] a_lat = '0;
	logic [7:0]        sel_mask = 8'h00;
	logic [7:0]        last_q = 8'h00;
	logic [2:0]        step = 3'h0;
	logic              window = 1'b0;
	logic              tmo = 1'b0;
	logic              tog1 = 1'b0;
	logic              tog2 = 1'b0;
	int                gen = 0;
	initial
	begin
		erased_mask = 8'h00;
		suspended = 1'b0;
		erasing = 1'b0;
	end
	function automatic logic good(input logic [2:0] st,
		input logic [ADDR_W-1:0] a, input logic [7:0] d);
		case (st)
			3'h0, 3'h3: good = a == UNLOCK1_ADDR && d == UNLOCK1_DATA;
			3'h1, 3'h4: good = a == UNLOCK2_ADDR && d == UNLOCK2_DATA;
			3'h2: good = a == UNLOCK1_ADDR && d == CMD_SETUP;
			default: good = d == CMD_SECTOR;
		endcase
	endfunction : good
	task automatic end_erase;
		gen++;
		window = 1'b0;
		erasing = 1'b0;
		suspended = 1'b0;
		tmo = 1'b0;
		sel_mask = 8'h00;
		step = 3'h0;
	endtask : end_erase
	// A newer arm cancels an older timer through the generation count
	task automatic arm(input int ns);
		int g;
		gen++;
		g = gen;
		fork
			begin
				#(ns);
				if (g == gen)
					expire();
			end
		join_none
	endtask : arm
	task automatic expire;
		if (window)
		begin
			window = 1'b0;
			arm(ERASE_NS);
		end
		else if (!tmo)
		begin
			erased_mask |= sel_mask;
			end_erase();
		end
	endtask : expire
	task automatic take_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		if (tmo && d == CMD_RESET)
			end_erase();
		else if (window && d == CMD_SECTOR)
		begin
			sel_mask[a[SECT_LSB +: SECT_W]] = 1'b1;
			arm(WINDOW_NS);
		end
		else if (erasing && d == CMD_SUSPEND)
		begin
			gen++;
			window = 1'b0;
			erasing = 1'b0;
			suspended = 1'b1;
		end
		else if (window)
			end_erase();
		else if (suspended && d == CMD_RESUME)
		begin
			suspended = 1'b0;
			erasing = 1'b1;
			arm(ERASE_NS);
		end
		else if (erasing || suspended)
			step = 3'h0;
		else if (d != CMD_RESET && good(step, a, d) && step == 3'h5)
		begin
			sel_mask = 8'h00;
			sel_mask[a[SECT_LSB +: SECT_W]] = 1'b1;
			erasing = 1'b1;
			window = 1'b1;
			tmo = overrun;
			step = 3'h0;
			arm(WINDOW_NS);
		end
		else if (d != CMD_RESET && good(step, a, d))
			step++;
		else
			step = 3'h0;
	endtask : take_write
	always @(negedge wr_n)
		a_lat = flash_addr;
	always @(posedge wr_n)
		take_write(a_lat, flash_dq_out);
	always @(negedge rd_n)
	begin
		tog1 = ~tog1;
		tog2 = ~tog2;
		if (suspended && sel_mask[flash_addr[SECT_LSB +: SECT_W]])
			last_q = {5'h10, tog2, 2'h0};
		else if (erasing)
			last_q = {1'b0, tog1, tmo, 1'b0, !window,
				tog2 & sel_mask[flash_addr[SECT_LSB +: SECT_W]], 2'h0};
		else
			last_q = {8{erased_mask[flash_addr[SECT_LSB +: SECT_W]]}};
	end
	// Undriven bus has no pull: show the inverse so stale data never passes
	assign flash_dq_in = rd_n ? ~last_q : last_q;
endmodule : fec_flash_model
`default_nettype wire

// >>> tb/fec_ctrl_tb.sv
// Self-checking bench for the flash erase controller over AXI4-Lite
`default_nettype none
module fec_ctrl_tb;
	import fec_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LIMIT = 40000;
	logic              clock = 1'b0;
	logic              resetn = 1'b0;
	logic [7:0]        awaddr = 8'h00;
	logic [7:0]        araddr = 8'h00;
	logic [31:0]       wdata = 32'h0;
	logic              awvalid = 1'b0;
	logic              wvalid = 1'b0;
	logic              bready = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready = 1'b0;
	logic              overrun = 1'b0;
	wire logic         awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]   bresp, rresp;
	wire logic [31:0]  rdata;
	wire logic [ADDR_W-1:0] f_addr;
	wire logic [7:0]   dq_in, dq_out, erased_mask;
	wire logic         dq_oe, cs_n, we_n, oe_n, suspended, erasing;
	int                errors = 0;
	int                cmp_count = 0;
	int                cycles = 0;
	logic [31:0]       rd;
	logic [1:0]        rsp;
	fec_ctrl i_fec_ctrl (.clock(clock), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_addr(f_addr),
		.flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.chip_select_n(cs_n), .write_strobe_n(we_n), .output_gate_n(oe_n));
	fec_flash_model i_fec_flash_model (.flash_addr(f_addr),
		.flash_dq_out(dq_out), .chip_select_n(cs_n), .write_strobe_n(we_n),
		.output_gate_n(oe_n), .overrun(overrun), .flash_dq_in(dq_in),
		.erased_mask(erased_mask), .suspended(suspended), .erasing(erasing));
	initial
		forever #12.5 clock = ~clock;
	task automatic give_verdict;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			errors++;
			$display("BAD watchdog expected finish seen hang");
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic got;
		got = 1'b0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got)
		begin
			@(posedge clock);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				got = 1'b1;
				r = bresp;
				bready <= 1'b0;
			end
		end
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic got;
		got = 1'b0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got)
		begin
			@(posedge clock);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				got = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask : axi_read
	task automatic rd_reg(input string what, input logic [7:0] a,
		input logic [31:0] ed, input logic [1:0] er);
		axi_read(a, rd, rsp);
		check(what, ed, rd);
		check(what, {30'h0, er}, {30'h0, rsp});
	endtask : rd_reg
	task automatic wr_cmd(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, rsp);
		check("write response", {30'h0, RESP_OKAY}, {30'h0, rsp});
	endtask : wr_cmd
	// Done shows with the sequencer parked; each new order clears it first
	task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
		do
			axi_read(REG_STAT, rd, rsp);
		while ((rd & mask) !== val);
	endtask : wait_stat
	task automatic start(input logic [7:0] mask);
		wr_cmd(REG_SECT, {24'h0, mask});
		wr_cmd(REG_CTRL, {29'h0, OP_ERASE});
		wait (erasing === 1'b1);
	endtask : start
	task automatic erase(input logic [7:0] mask, input logic [7:0] exp);
		start(mask);
		wait_stat(32'h9, 32'h9);
		check("erased sectors", {24'h0, exp}, {24'h0, erased_mask});
		axi_read(REG_LAST, rd, rsp);
		check("last poll bit", 32'h1, {31'h0, rd[POLL_BIT]});
	endtask : erase
	initial
	begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		rd_reg("status at reset", REG_STAT, 32'h0, RESP_OKAY);
		rd_reg("control at reset", REG_CTRL, 32'h0, RESP_OKAY);
		rd_reg("unmapped read", 8'h10, 32'h0, RESP_SLVERR);
		axi_write(8'h14, 32'h1, rsp);
		check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		erase(8'h04, 8'h04);
		erase(8'h82, 8'h86);
		start(8'h10);
		wr_cmd(REG_CTRL, {29'h0, OP_SUSPEND});
		wait_stat(32'h20, 32'h20);
		check("suspended", 32'h1, {31'h0, suspended});
		check("held sectors", 32'h86, {24'h0, erased_mask});
		wr_cmd(REG_CTRL, {29'h0, OP_RESUME});
		wait (suspended === 1'b0);
		wait_stat(32'h9, 32'h9);
		check("resumed sectors", 32'h96, {24'h0, erased_mask});
		overrun <= 1'b1;
		start(8'h01);
		wait_stat(32'h10, 32'h10);
		axi_read(REG_LAST, rd, rsp);
		check("timeout bit", 32'h1, {31'h0, rd[TMO_BIT]});
		overrun <= 1'b0;
		wr_cmd(REG_CTRL, {29'h0, OP_RESET});
		wait_stat(32'h9, 32'h9);
		check("erase abandoned", 32'h0, {31'h0, erasing});
		check("no sector erased", 32'h96, {24'h0, erased_mask});
		give_verdict();
	end
endmodule : fec_ctrl_tb
`default_nettype wire
